// ===== fault_response_regs.vh
`ifndef FAULT_RESPONSE_REGS_VH
`define FAULT_RESPONSE_REGS_VH
`define OC2_CTRL_ADDR 8'hB6
`define LOWBUS_CTRL_ADDR 8'hB7
`define GLOBAL_CTRL_ADDR 8'hB0
`define PHASE_CFG_ADDR 8'hBC
`define IRQ_STATUS_ADDR 8'hD5
`define CHAN_STATUS_ADDR 8'hDA
`define IRQ_MASK_ADDR 8'hE0
`define IRQ_PHASE_BIT 0
`define OC2_STATUS_BIT 1
`define IRQ_LATCH_BIT 2
`define IND_EN_BIT 7
`define CODE_HI_BIT 7
`define CODE_LO_BIT 6
`define PHASE_REMOVE_BIT 5
`define OC2_CTRL_RESET 8'h00
`define LOWBUS_CTRL_RESET 8'h00
`define GLOBAL_CTRL_RESET 8'h00
`define PHASE_CFG_RESET 8'h40
`define IRQ_MASK_RESET 8'h00
`define IRQ_STATUS_RESET 8'h00
`define CHAN_STATUS_RESET 4'h0
`define CODE_FLAG 2'h0
`define CODE_HICCUP 2'h1
`define CODE_LATCH 2'h2
`define HICCUP_DELAY_MS 500
`define CLK_FREQ_HZ 10000000
// 500 ms at 10 MHz, sized to the delay counter
`define HICCUP_CYCLES 23'd5000000
`endif

// ===== fault_response_selector.v
`timescale 1ns/1ps
`include "fault_response_regs.vh"
module fault_response_selector #(
   parameter [22:0] HICCUP_CYCLES = `HICCUP_CYCLES
) (
   // clock and reset
   input wire clk_i,
   input wire srst_i,
   // register port
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   // fault inputs and pins
   input wire [3:0] second_level_overcurrent_i,
   input wire [1:0] mode_code_i,
   input wire switch_en_i,
   input wire chip_en_i,
   // outputs
   output reg switching_on_o,
   output reg fault_flag_n_o,
   output reg irq_o
);
   localparam ST_RUN = 2'd0;
   localparam ST_HICCUP = 2'd1;
   localparam ST_LATCH = 2'd2;

   reg [7:0] oc2_ctrl_reg;
   reg [7:0] lowbus_ctrl_reg;
   reg [7:0] global_ctrl_reg;
   reg [7:0] phase_cfg_reg;
   reg [7:0] irq_status_reg;
   reg [7:0] irq_mask_reg;
   reg [3:0] chan_status_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [22:0] delay_reg;
   reg [22:0] delay_next;
   reg en_prev_reg;

   // count of ones in a four-bit field
   function [2:0] ones4;
      input [3:0] v;
      begin
         ones4 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]};
      end
   endfunction

   // write strobe aimed at one register address
   function wr_hit;
      input wr;
      input [7:0] a;
      input [7:0] target;
      begin
         wr_hit = wr && (a == target);
      end
   endfunction

   // read multiplexer: unmapped addresses read as zero
   function [7:0] read_mux;
      input [7:0] a;
      input [7:0] oc2_ctrl;
      input [7:0] lowbus_ctrl;
      input [7:0] global_ctrl;
      input [7:0] phase_cfg;
      input [7:0] irq_status;
      input [7:0] irq_mask;
      input [3:0] chan_status;
      begin
         case (a)
            `OC2_CTRL_ADDR: begin
               read_mux = oc2_ctrl;
            end
            `LOWBUS_CTRL_ADDR: begin
               read_mux = lowbus_ctrl;
            end
            `GLOBAL_CTRL_ADDR: begin
               read_mux = global_ctrl;
            end
            `PHASE_CFG_ADDR: begin
               read_mux = phase_cfg;
            end
            `IRQ_STATUS_ADDR: begin
               read_mux = irq_status;
            end
            `IRQ_MASK_ADDR: begin
               read_mux = irq_mask;
            end
            `CHAN_STATUS_ADDR: begin
               read_mux = {4'h0, chan_status};
            end
            default: begin
               read_mux = 8'h00;
            end
         endcase
      end
   endfunction

   wire [1:0] reg_code = {oc2_ctrl_reg[`CODE_HI_BIT], oc2_ctrl_reg[`CODE_LO_BIT]};
   wire [1:0] code = global_ctrl_reg[`IND_EN_BIT] ? reg_code : mode_code_i;
   wire oc2_any = |second_level_overcurrent_i;
   // phase config: [7:4] configured phases, [3:0] disable mask
   wire [2:0] disabled_cnt = ones4(phase_cfg_reg[3:0]);
   wire [3:0] cfg_phases = phase_cfg_reg[7:4];
   wire phase_fault = oc2_ctrl_reg[`PHASE_REMOVE_BIT] &&
      ({1'b0, disabled_cnt, 1'b0} > {1'b0, cfg_phases});
   wire fault_now = oc2_any | phase_fault;
   wire enables = switch_en_i & chip_en_i;
   wire en_rise = enables & ~en_prev_reg;
   wire trig_hiccup = fault_now && (code == `CODE_HICCUP);
   wire trig_latch = fault_now && (code == `CODE_LATCH);
   wire [7:0] irq_set = {5'h00, state_next == ST_LATCH && state_reg != ST_LATCH,
      oc2_any, phase_fault};
   wire wr_clr = wr_i && addr_i == `IRQ_STATUS_ADDR;
   wire chan_clr = wr_i && addr_i == `CHAN_STATUS_ADDR;

   // sticky status after this cycle: a set in the clearing cycle wins
   wire [7:0] clr_mask = wr_clr ? wdata_i : 8'h00;
   wire [7:0] irq_status_next = (irq_status_reg & ~clr_mask) | irq_set;
   wire [3:0] chan_clr_mask = chan_clr ? wdata_i[3:0] : 4'h0;
   wire [3:0] chan_status_next = (chan_status_reg & ~chan_clr_mask)
      | second_level_overcurrent_i;
   // delay reached: the fault-free interval has run its full length
   wire hiccup_done = delay_reg >= HICCUP_CYCLES - 23'd1;

   // next response state
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            // codes 00 and 11 keep switching
            if (trig_latch) begin
               state_next = ST_LATCH;
            end else if (trig_hiccup) begin
               state_next = ST_HICCUP;
            end
         end
         ST_HICCUP: begin
            if (trig_latch) begin
               state_next = ST_LATCH;
            end else if (!fault_now && hiccup_done) begin
               state_next = ST_RUN;
            end
         end
         ST_LATCH: begin
            // only a fresh rise of the enables, with the fault gone, restarts
            if (en_rise && !fault_now) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   // hiccup delay: counts fault-free cycles, any fault starts it over
   always @* begin
      delay_next = delay_reg;
      case (state_reg)
         ST_RUN: begin
            delay_next = 23'd0;
         end
         ST_HICCUP: begin
            if (fault_now) begin
               delay_next = 23'd0;
            end else if (!hiccup_done) begin
               delay_next = delay_reg + 23'd1;
            end
         end
         default: begin
            delay_next = 23'd0;
         end
      endcase
   end

   // response code register for the overcurrent reaction
   always @(posedge clk_i) begin
      if (srst_i) begin
         oc2_ctrl_reg <= `OC2_CTRL_RESET;
      end else if (wr_hit(wr_i, addr_i, `OC2_CTRL_ADDR)) begin
         oc2_ctrl_reg <= wdata_i;
      end
   end

   // low-bus response codes, storage only
   always @(posedge clk_i) begin
      if (srst_i) begin
         lowbus_ctrl_reg <= `LOWBUS_CTRL_RESET;
      end else if (wr_hit(wr_i, addr_i, `LOWBUS_CTRL_ADDR)) begin
         lowbus_ctrl_reg <= wdata_i;
      end
   end

   // global control, bit 7 selects register codes over the mode pin
   always @(posedge clk_i) begin
      if (srst_i) begin
         global_ctrl_reg <= `GLOBAL_CTRL_RESET;
      end else if (wr_hit(wr_i, addr_i, `GLOBAL_CTRL_ADDR)) begin
         global_ctrl_reg <= wdata_i;
      end
   end

   // phase count and disable mask
   always @(posedge clk_i) begin
      if (srst_i) begin
         phase_cfg_reg <= `PHASE_CFG_RESET;
      end else if (wr_hit(wr_i, addr_i, `PHASE_CFG_ADDR)) begin
         phase_cfg_reg <= wdata_i;
      end
   end

   // interrupt mask, same layout as the status register
   always @(posedge clk_i) begin
      if (srst_i) begin
         irq_mask_reg <= `IRQ_MASK_RESET;
      end else if (wr_hit(wr_i, addr_i, `IRQ_MASK_ADDR)) begin
         irq_mask_reg <= wdata_i;
      end
   end

   // sticky event status, write one to clear
   always @(posedge clk_i) begin
      if (srst_i) begin
         irq_status_reg <= `IRQ_STATUS_RESET;
      end else begin
         irq_status_reg <= irq_status_next;
      end
   end

   // sticky per-channel record, write one to clear
   always @(posedge clk_i) begin
      if (srst_i) begin
         chan_status_reg <= `CHAN_STATUS_RESET;
      end else begin
         chan_status_reg <= chan_status_next;
      end
   end

   // response state and delay; enables idle high, so no false rise after reset
   always @(posedge clk_i) begin
      if (srst_i) begin
         state_reg <= ST_RUN;
         delay_reg <= 23'd0;
         en_prev_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         delay_reg <= delay_next;
         en_prev_reg <= enables;
      end
   end

   // switching permission, registered
   always @(posedge clk_i) begin
      if (srst_i) begin
         switching_on_o <= 1'b0;
      end else begin
         switching_on_o <= enables && state_next == ST_RUN;
      end
   end

   // fault flag low while the phase or overcurrent status is set
   always @(posedge clk_i) begin
      if (srst_i) begin
         fault_flag_n_o <= 1'b1;
      end else begin
         fault_flag_n_o <= ~(|(irq_status_next & 8'h03));
      end
   end

   // level interrupt from unmasked status
   always @(posedge clk_i) begin
      if (srst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_status_next & irq_mask_reg);
      end
   end

   // read data stand for one cycle after the read strobe, zero otherwise
   always @(posedge clk_i) begin
      if (srst_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         rdata_o <= read_mux(addr_i, oc2_ctrl_reg, lowbus_ctrl_reg, global_ctrl_reg,
            phase_cfg_reg, irq_status_reg, irq_mask_reg, chan_status_reg);
      end else begin
         rdata_o <= 8'h00;
      end
   end
endmodule // fault_response_selector

// ===== fault_response_selector_sva.sv
`timescale 1ns/1ps
module fault_response_selector_sva #(parameter [22:0] HICCUP_CYCLES = 20) (
   // clock, register port, pins, outputs
   input wire clk_i, input wire srst_i, input wire [7:0] addr_i, input wire [7:0] wdata_i,
   input wire wr_i, input wire rd_i, input wire [7:0] rdata_o,
   input wire [3:0] second_level_overcurrent_i, input wire [1:0] mode_code_i,
   input wire switch_en_i, input wire chip_en_i, input wire switching_on_o,
   input wire fault_flag_n_o, input wire irq_o
);
   localparam [23:0] FULL = HICCUP_CYCLES + 24'h2;
   reg ind_reg;
   reg [1:0] code_reg;
   reg [23:0] free_reg;
   wire [1:0] code = ind_reg ? code_reg : mode_code_i;
   wire oc = |second_level_overcurrent_i;
   wire en = switch_en_i & chip_en_i;
   // shadow of the selected code and a saturating count of overcurrent-free cycles
   always @(posedge clk_i) begin
      if (srst_i) begin
         ind_reg <= 1'b0;
         code_reg <= 2'h0;
         free_reg <= FULL;
      end else begin
         if (wr_i && addr_i == 8'hB0) ind_reg <= wdata_i[7];
         if (wr_i && addr_i == 8'hB6) code_reg <= wdata_i[7:6];
         free_reg <= oc ? 24'h0 : (free_reg > HICCUP_CYCLES ? FULL : free_reg + 24'h1);
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   sequence s_trip; code == 2'h2 && oc ##1 !switching_on_o; endsequence
   property p_flag; oc |=> !fault_flag_n_o; endproperty
   a_flag: assert property (p_flag) else $error("flag");
   property p_stop; (code[1] ^ code[0]) && oc |=> !switching_on_o; endproperty
   a_stop: assert property (p_stop) else $error("stop");
   property p_keep; code[1] == code[0] && switching_on_o && en |=> switching_on_o; endproperty
   a_keep: assert property (p_keep) else $error("keep");
   property p_wait; code == 2'h1 && free_reg < HICCUP_CYCLES |-> !switching_on_o; endproperty
   a_wait: assert property (p_wait) else $error("wait");
   property p_back; code == 2'h1 && free_reg == FULL && en && $past(en) && !$past(srst_i)
      |-> switching_on_o; endproperty
   a_back: assert property (p_back) else $error("back");
   property p_latch; s_trip |=> !switching_on_o [*8]; endproperty
   a_latch: assert property (p_latch) else $error("latch");
   property p_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("idle");
   property p_reset; disable iff (1'b0) srst_i |=> rdata_o == 8'h00 && fault_flag_n_o
      && !switching_on_o && !irq_o; endproperty
   a_reset: assert property (p_reset) else $error("reset");
endmodule // fault_response_selector_sva
bind fault_response_selector fault_response_selector_sva #(.HICCUP_CYCLES(HICCUP_CYCLES)) chk_u (
   .clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .second_level_overcurrent_i,
   .mode_code_i, .switch_en_i, .chip_en_i, .switching_on_o, .fault_flag_n_o, .irq_o);

// ===== fault_response_selector_bench.sv
`timescale 1ns/1ps
`include "fault_response_regs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module fault_response_selector_bench;
   reg clk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, switch_en_i = 1, chip_en_i = 1;
   reg [7:0] addr_i = 0, wdata_i = 0;
   reg [3:0] second_level_overcurrent_i = 0;
   reg [1:0] mode_code_i = 0, c;
   wire [7:0] rdata_o;
   wire switching_on_o, fault_flag_n_o, irq_o;
   integer n_mismatch = 0, tests_run = 0, j;
   fault_response_selector #(.HICCUP_CYCLES(20)) dut_u (.clk_i, .srst_i, .addr_i, .wdata_i,
      .wr_i, .rd_i, .rdata_o, .second_level_overcurrent_i, .mode_code_i, .switch_en_i,
      .chip_en_i, .switching_on_o, .fault_flag_n_o, .irq_o);
   initial forever #50 clk_i = ~clk_i;
   task cyc(input integer n); begin repeat (n) @(posedge clk_i); #1; end endtask
   task wr(input [7:0] a, input [7:0] d); begin
      @(posedge clk_i); wr_i <= 1; addr_i <= a; wdata_i <= d;
      @(posedge clk_i); wr_i <= 0;
   end endtask
   task rd(input [7:0] a, input [7:0] e); begin
      @(posedge clk_i); rd_i <= 1; addr_i <= a;
      @(posedge clk_i); rd_i <= 0; #1 `CHK("rdata", e, rdata_o)
   end endtask
   task tally_and_finish; begin
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   end endtask
   initial begin #500000; n_mismatch++; tally_and_finish; end
   initial begin
      cyc(4); srst_i <= 0; cyc(1);
      rd(`LOWBUS_CTRL_ADDR, 8'h00);
      wr(`LOWBUS_CTRL_ADDR, 8'hA5);
      rd(`LOWBUS_CTRL_ADDR, 8'hA5);
      rd(`OC2_CTRL_ADDR, 8'h00);
      rd(`PHASE_CFG_ADDR, 8'h40);
      rd(8'h10, 8'h00);
      wr(`IRQ_MASK_ADDR, 8'h02);
      $display("test regs done");
      // pin code and register code disagree, so only the selected one can match
      for (j = 0; j < 8; j++) begin
         c = j[1:0];
         mode_code_i <= j < 4 ? c : ~c;
         wr(`GLOBAL_CTRL_ADDR, j < 4 ? 8'h00 : 8'h80);
         wr(`OC2_CTRL_ADDR, {j < 4 ? ~c : c, 6'h00});
         second_level_overcurrent_i <= 4'h1 << c; cyc(2); second_level_overcurrent_i <= 0;
         `CHK("flag", 1'b0, fault_flag_n_o)
         `CHK("irq", 1'b1, irq_o)
         `CHK("sw", c[0] ~^ c[1], switching_on_o)
         cyc(10); second_level_overcurrent_i <= 4'h1 << c; cyc(1);
         second_level_overcurrent_i <= 0; cyc(15);
         `CHK("sw", c[0] ~^ c[1], switching_on_o)
         cyc(10); `CHK("sw", c != 2'h2, switching_on_o)
         rd(`CHAN_STATUS_ADDR, 8'h01 << c);
         switch_en_i <= 0; cyc(1); switch_en_i <= 1; cyc(3);
         `CHK("sw", 1'b1, switching_on_o)
         wr(`IRQ_STATUS_ADDR, 8'hFF); wr(`CHAN_STATUS_ADDR, 8'hFF); cyc(1);
         `CHK("flag", 1'b1, fault_flag_n_o)
         `CHK("irq", 1'b0, irq_o)
      end
      $display("test codes done");
      wr(`PHASE_CFG_ADDR, 8'h4F); wr(`OC2_CTRL_ADDR, 8'h80); cyc(3);
      `CHK("sw", 1'b1, switching_on_o)
      rd(`IRQ_STATUS_ADDR, 8'h00);
      wr(`PHASE_CFG_ADDR, 8'h43); wr(`OC2_CTRL_ADDR, 8'hA0); cyc(3);
      `CHK("sw", 1'b1, switching_on_o)
      wr(`PHASE_CFG_ADDR, 8'h47); cyc(3);
      `CHK("sw", 1'b0, switching_on_o)
      `CHK("flag", 1'b0, fault_flag_n_o)
      wr(`PHASE_CFG_ADDR, 8'h40); chip_en_i <= 0; cyc(1); chip_en_i <= 1; cyc(3);
      `CHK("sw", 1'b1, switching_on_o)
      $display("test phase done");
      tally_and_finish;
   end
endmodule // fault_response_selector_bench
